// File: logic/flyback_protection_monitor.sv
// Protection and power-factor supervision of a flyback controller
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/10ps
// Operation
// - Notch on after sync held blanking periods
// - Enhanced correction on when gain nonzero
// - Modulate on-time when enabled, stable, QR/DISCONTINUOUS_MODE
// - Overcurrent after blanking, always auto-restart
// - Second level: lowest fixed level above limit, else highest
// - Output undervoltage in regulated mode, selectable
// - Startup undervoltage over maximum startup time
// - Overvoltage after quarter half-period, selectable
// - Half period measured, or preset without sync or in burst
// - Demag shortage after half a half-period
// - Pre-startup low input forces auto-restart
// - Input undervoltage after ten half periods
// - Burst input undervoltage needs both enables
// - Input undervoltage always auto-restart
// - Gate disabled promptly after any trigger
module flyback_protection_monitor #(
	parameter int PRESET_HALF_CYCLES = flyback_pkg::PRESET_HALF_CYCLES,
	parameter int SAMPLE_WIDTH       = 12
) (
	// Clock, reset, enable
	input  wire logic                    clock,
	input  wire logic                    rst,
	input  wire logic                    clockEnable,
	// APB slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [7:0]              paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	// Operating mode
	input  wire logic                    quasiResonantValleyOneMode,
	input  wire logic                    discontinuousMode,
	input  wire logic                    burstMode,
	input  wire logic                    regulatedMode,
	input  wire logic                    startupPhase,
	input  wire logic                    preStartupCheck,
	// Line synchronisation and timing
	input  wire logic                    lineSyncValid,
	input  wire logic [17:0]             measuredHalfPeriod,
	input  wire logic                    burstPeriodTick,
	// Sampled estimates
	input  wire logic [SAMPLE_WIDTH-1:0] inputVoltage,
	input  wire logic [SAMPLE_WIDTH-1:0] outputVoltage,
	input  wire logic [SAMPLE_WIDTH-1:0] outputCurrent,
	input  wire logic [SAMPLE_WIDTH-1:0] currentSense,
	input  wire logic                    demagSenseFail,
	// Feedback path
	input  wire logic                    feedbackStable,
	input  wire logic [7:0]              phaseAngle,
	input  wire logic [15:0]             mappedOnTime,
	output logic      [15:0]             modulatedOnTime,
	output logic                         notchEnable,
	output logic      [3:0]              notchQuality,
	output logic                         enhancedPowerFactor,
	// Protection reaction
	input  wire logic                    faultClear,
	output logic                         gateDisable,
	output logic      [2:0]              faultCause,
	output logic                         autoRestartRequest,
	output logic                         latchRequest,
	output logic                         irq
);

	localparam int TW = flyback_pkg::TIMER_WIDTH;
	localparam int EC = flyback_pkg::EVENT_COUNT;

	logic [4:0]  control_r; // Enables and reaction selects
	logic [7:0]  capGain_r; // Capacitance compensation gain
	logic [7:0]  notchBlank_r; // Half periods of sync before notch
	logic [3:0]  notchQuality_r; // Notch quality factor
	logic [11:0] ocpLimit_r; // Low-line first current limit
	logic [TW-1:0] ocpBlank_r; // Overcurrent blanking, cycles
	logic [11:0] outUvLevel_r; // Output undervoltage level
	logic [11:0] startLowLevel_r; // Startup output low level
	logic [TW-1:0] ouvBlank_r; // Output undervoltage blanking
	logic [11:0] outOvLevel_r; // Output overvoltage level
	logic [11:0] inUvLevel_r; // Input undervoltage level
	logic [11:0] inStartMin_r; // Minimum input for startup
	logic [TW-1:0] startMax_r; // Maximum startup duration
	logic [EC-1:0] status_r; // Sticky event flags
	logic [EC-1:0] mask_r; // Interrupt mask
	logic [31:0] prdata_r; // Captured read data
	logic        slverr_r; // Captured unmapped flag

	logic [17:0] halfPeriod; // Active half period in cycles
	logic [17:0] halfCount_r; // Half period phase counter
	logic        halfTick; // One cycle per half period
	logic [7:0]  syncHeld_r; // Half periods with sync held
	logic        qrOrDcm; // Line-synchronised modes
	logic [11:0] ocp2Level; // Selected second current level
	logic [1:0]  ocp2Select; // Index of the chosen level
	logic [EC-1:0] cond; // Per-event trigger conditions
	logic [EC-1:0] stepEn; // Per-event count enable
	logic [TW-1:0] limit [EC]; // Per-event expiry count
	logic [EC-1:0] fired; // Per-event expiry
	logic [2:0]  firstCause; // Lowest firing event index
	logic        gateDisable_r; // Fault holds gate off
	logic [2:0]  faultCause_r; // Captured cause code
	logic        autoReq_r; // Auto-restart request pulse
	logic        latchReq_r; // Latch request pulse
	logic        setupRead; // APB read setup phase
	logic        accessWrite; // APB write access phase
	logic        accessRead; // APB read access phase
	logic [15:0] gainPhase; // Gain times phase angle
	logic [12:0] loadTerm; // Input plus current minus quarter output, floored at zero
	logic [28:0] corrWide; // Full correction product
	logic [16:0] onTimeSum; // On-time with correction

	assign qrOrDcm = quasiResonantValleyOneMode || discontinuousMode;

	// Half period from measurement or preset
	always_comb
	begin
		if (lineSyncValid && !burstMode)
			halfPeriod = measuredHalfPeriod;
		else
			halfPeriod = 18'(PRESET_HALF_CYCLES);
	end

	// Half period tick generator
	always_ff @(posedge clock)
	begin
		if (rst)
			halfCount_r <= '0;
		else if (clockEnable)
		begin
			if (halfCount_r + 18'h1 >= halfPeriod)
				halfCount_r <= '0;
			else
				halfCount_r <= halfCount_r + 18'h1;
		end
	end
	assign halfTick = clockEnable && (halfCount_r + 18'h1 >= halfPeriod);

	// Count half periods of held synchronisation for the notch
	always_ff @(posedge clock)
	begin
		if (rst)
			syncHeld_r <= '0;
		else if (clockEnable)
		begin
			if (!(lineSyncValid && qrOrDcm))
				syncHeld_r <= '0;
			else if (halfTick && syncHeld_r != 8'hFF)
				syncHeld_r <= syncHeld_r + 8'h01;
		end
	end
	assign notchEnable = lineSyncValid && qrOrDcm
		&& (syncHeld_r >= notchBlank_r);
	assign notchQuality = notchQuality_r;

	// Enhanced power factor and on-time modulation
	assign enhancedPowerFactor = (capGain_r != 8'h00);
	always_comb
	begin
		gainPhase = capGain_r * phaseAngle;
		if (13'(inputVoltage) + 13'(outputCurrent) > 13'(outputVoltage >> 2))
			loadTerm = 13'(inputVoltage) + 13'(outputCurrent)
				- 13'(outputVoltage >> 2);
		else
			loadTerm = 13'h0;
		corrWide = gainPhase * loadTerm;
		onTimeSum = 17'(mappedOnTime) + 17'(corrWide[28:20]);
	end

	// Modulated on-time register
	always_ff @(posedge clock)
	begin
		if (rst)
			modulatedOnTime <= '0;
		else if (clockEnable)
		begin
			if (enhancedPowerFactor && feedbackStable && qrOrDcm)
				modulatedOnTime <= onTimeSum[16] ? 16'hFFFF
					: onTimeSum[15:0];
			else
				modulatedOnTime <= mappedOnTime;
		end
	end

	// Lowest fixed level still above the configured limit, else the highest level
	always_comb
	begin
		if (flyback_pkg::OCP2_LEVEL_0 > ocpLimit_r)
			ocp2Select = 2'd0;
		else if (flyback_pkg::OCP2_LEVEL_1 > ocpLimit_r)
			ocp2Select = 2'd1;
		else if (flyback_pkg::OCP2_LEVEL_2 > ocpLimit_r)
			ocp2Select = 2'd2;
		else
			ocp2Select = 2'd3;
		case (ocp2Select)
			2'd0: ocp2Level = flyback_pkg::OCP2_LEVEL_0;
			2'd1: ocp2Level = flyback_pkg::OCP2_LEVEL_1;
			2'd2: ocp2Level = flyback_pkg::OCP2_LEVEL_2;
			default: ocp2Level = flyback_pkg::OCP2_LEVEL_3;
		endcase
	end

	// Trigger conditions, count enables and limits per event
	always_comb
	begin
		cond = '0;
		stepEn = '1;
		cond[flyback_pkg::EV_OVERCURRENT] = 12'(currentSense) > ocp2Level;
		limit[flyback_pkg::EV_OVERCURRENT] = ocpBlank_r + 1'b1;
		cond[flyback_pkg::EV_OUTPUT_UV] = regulatedMode && !burstMode
			&& control_r[flyback_pkg::CTL_OUV_ENABLE]
			&& (12'(outputVoltage) < outUvLevel_r);
		limit[flyback_pkg::EV_OUTPUT_UV] = ouvBlank_r + 1'b1;
		cond[flyback_pkg::EV_STARTUP_UV] = startupPhase
			&& (12'(outputVoltage) < startLowLevel_r);
		limit[flyback_pkg::EV_STARTUP_UV] = startMax_r;
		cond[flyback_pkg::EV_OUTPUT_OV] = !burstMode
			&& (12'(outputVoltage) > outOvLevel_r);
		limit[flyback_pkg::EV_OUTPUT_OV] = TW'(halfPeriod >> 2) + 1'b1;
		cond[flyback_pkg::EV_DEMAG_SHORT] = !burstMode && demagSenseFail;
		limit[flyback_pkg::EV_DEMAG_SHORT] = TW'(halfPeriod >> 1) + 1'b1;
		cond[flyback_pkg::EV_INPUT_UV] = (startupPhase || regulatedMode)
			&& qrOrDcm && !burstMode
			&& control_r[flyback_pkg::CTL_INUV_ENABLE]
			&& (12'(inputVoltage) < inUvLevel_r);
		stepEn[flyback_pkg::EV_INPUT_UV] = halfTick;
		limit[flyback_pkg::EV_INPUT_UV] = TW'(flyback_pkg::INPUT_UV_PERIODS);
		cond[flyback_pkg::EV_INPUT_UV_BURST] = burstMode
			&& control_r[flyback_pkg::CTL_INUV_ENABLE]
			&& control_r[flyback_pkg::CTL_BURST_IN_EN]
			&& (12'(inputVoltage) < inUvLevel_r);
		stepEn[flyback_pkg::EV_INPUT_UV_BURST] = burstPeriodTick;
		limit[flyback_pkg::EV_INPUT_UV_BURST] =
			TW'(flyback_pkg::INPUT_UV_PERIODS);
		cond[flyback_pkg::EV_PRESTART_LOW] = preStartupCheck
			&& control_r[flyback_pkg::CTL_INUV_ENABLE]
			&& (12'(inputVoltage) < inStartMin_r);
		limit[flyback_pkg::EV_PRESTART_LOW] = TW'(1);
	end

	// One blanking timer per protection event
	for (genvar i = 0; i < EC; i++)
	begin : gTimer
		blank_timer #(
			.WIDTH       (TW)
		) uTimer (
			.clock       (clock),
			.rst         (rst),
			.clockEnable (clockEnable),
			.condition   (cond[i]),
			.step        (stepEn[i]),
			.limit       (limit[i]),
			.expired     (fired[i])
		);
	end

	// Lowest index among firing events names the cause
	always_comb
	begin
		firstCause = 3'd0;
		for (int k = EC - 1; k >= 0; k--)
			if (fired[k])
				firstCause = 3'(k);
	end

	// Fault capture: gate off, cause code, one reaction pulse
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			gateDisable_r <= 1'b0;
			faultCause_r <= 3'd0;
			autoReq_r <= 1'b0;
			latchReq_r <= 1'b0;
		end
		else if (clockEnable)
		begin
			autoReq_r <= 1'b0;
			latchReq_r <= 1'b0;
			if (!gateDisable_r && (fired != '0))
			begin
				gateDisable_r <= 1'b1;
				faultCause_r <= firstCause;
				if ((firstCause == 3'(flyback_pkg::EV_OUTPUT_UV)
					&& control_r[flyback_pkg::CTL_OUV_LATCH])
					|| (firstCause == 3'(flyback_pkg::EV_OUTPUT_OV)
					&& control_r[flyback_pkg::CTL_OVP_LATCH]))
					latchReq_r <= 1'b1;
				else
					autoReq_r <= 1'b1;
			end
			else if (faultClear)
				gateDisable_r <= 1'b0;
		end
	end
	assign gateDisable = gateDisable_r;
	assign faultCause = faultCause_r;
	assign autoRestartRequest = autoReq_r;
	assign latchRequest = latchReq_r;

	// APB phase decode
	assign setupRead = psel && !penable && !pwrite;
	assign accessWrite = psel && penable && pwrite && clockEnable;
	assign accessRead = psel && penable && !pwrite && clockEnable;
	assign pready = clockEnable;
	assign prdata = prdata_r;
	assign pslverr = slverr_r;

	// Register writes
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			control_r <= '0;
			capGain_r <= '0;
			notchBlank_r <= '0;
			notchQuality_r <= '0;
			ocpLimit_r <= '0;
			ocpBlank_r <= '0;
			outUvLevel_r <= '0;
			startLowLevel_r <= '0;
			ouvBlank_r <= '0;
			outOvLevel_r <= '0;
			inUvLevel_r <= '0;
			inStartMin_r <= '0;
			startMax_r <= '0;
			mask_r <= '0;
		end
		else if (accessWrite)
		begin
			if (paddr == flyback_pkg::REG_CONTROL)
				control_r <= pwdata[4:0];
			else if (paddr == flyback_pkg::REG_CAP_GAIN)
				capGain_r <= pwdata[7:0];
			else if (paddr == flyback_pkg::REG_NOTCH)
			begin
				notchBlank_r <= pwdata[7:0];
				notchQuality_r <= pwdata[11:8];
			end
			else if (paddr == flyback_pkg::REG_OCP_LIMIT)
				ocpLimit_r <= pwdata[11:0];
			else if (paddr == flyback_pkg::REG_OCP_BLANK)
				ocpBlank_r <= pwdata[TW-1:0];
			else if (paddr == flyback_pkg::REG_OUT_LEVELS)
			begin
				outUvLevel_r <= pwdata[11:0];
				startLowLevel_r <= pwdata[27:16];
			end
			else if (paddr == flyback_pkg::REG_OUV_BLANK)
				ouvBlank_r <= pwdata[TW-1:0];
			else if (paddr == flyback_pkg::REG_OVP_LEVEL)
				outOvLevel_r <= pwdata[11:0];
			else if (paddr == flyback_pkg::REG_IN_LEVELS)
			begin
				inUvLevel_r <= pwdata[11:0];
				inStartMin_r <= pwdata[27:16];
			end
			else if (paddr == flyback_pkg::REG_START_MAX)
				startMax_r <= pwdata[TW-1:0];
			else if (paddr == flyback_pkg::REG_MASK)
				mask_r <= pwdata[EC-1:0];
		end
	end

	// Sticky status, read clears, a new event wins over the clear
	always_ff @(posedge clock)
	begin
		if (rst)
			status_r <= '0;
		else if (clockEnable)
		begin
			if (accessRead && paddr == flyback_pkg::REG_STATUS)
				status_r <= fired;
			else
				status_r <= status_r | fired;
		end
	end
	assign irq = (status_r & mask_r) != '0;

	// Read data captured in the setup phase
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			prdata_r <= flyback_pkg::RESET_ZERO;
			slverr_r <= 1'b0;
		end
		else if (clockEnable && setupRead)
		begin
			slverr_r <= 1'b0;
			prdata_r <= flyback_pkg::RESET_ZERO;
			if (paddr == flyback_pkg::REG_CONTROL)
				prdata_r <= 32'(control_r);
			else if (paddr == flyback_pkg::REG_CAP_GAIN)
				prdata_r <= 32'(capGain_r);
			else if (paddr == flyback_pkg::REG_NOTCH)
				prdata_r <= {20'h0_0000, notchQuality_r, notchBlank_r};
			else if (paddr == flyback_pkg::REG_OCP_LIMIT)
				prdata_r <= 32'(ocpLimit_r);
			else if (paddr == flyback_pkg::REG_OCP_BLANK)
				prdata_r <= 32'(ocpBlank_r);
			else if (paddr == flyback_pkg::REG_OUT_LEVELS)
				prdata_r <= {4'h0, startLowLevel_r, 4'h0, outUvLevel_r};
			else if (paddr == flyback_pkg::REG_OUV_BLANK)
				prdata_r <= 32'(ouvBlank_r);
			else if (paddr == flyback_pkg::REG_OVP_LEVEL)
				prdata_r <= 32'(outOvLevel_r);
			else if (paddr == flyback_pkg::REG_IN_LEVELS)
				prdata_r <= {4'h0, inStartMin_r, 4'h0, inUvLevel_r};
			else if (paddr == flyback_pkg::REG_START_MAX)
				prdata_r <= 32'(startMax_r);
			else if (paddr == flyback_pkg::REG_STATUS)
				prdata_r <= 32'(status_r | fired);
			else if (paddr == flyback_pkg::REG_MASK)
				prdata_r <= 32'(mask_r);
			else if (paddr == flyback_pkg::REG_INFO)
				prdata_r <= {24'h00_0000, faultCause_r, gateDisable_r,
					enhancedPowerFactor, notchEnable, ocp2Select};
			else
				slverr_r <= 1'b1;
		end
	end

endmodule

// File: logic/flyback_pkg.sv
// Shared constants for the flyback protection monitor
package flyback_pkg;

	// Clock and half-sine timing
	localparam int CLOCK_PERIOD_NS     = 50;
	localparam int PRESET_HALF_NS      = 9823000;
	localparam int PRESET_HALF_CYCLES  = PRESET_HALF_NS / CLOCK_PERIOD_NS;
	localparam int INPUT_UV_PERIODS    = 10;
	localparam int TIMER_WIDTH         = 24;
	localparam int EVENT_COUNT         = 8;

	// Protection event indices, also the status bit positions
	localparam int EV_OVERCURRENT      = 0;
	localparam int EV_OUTPUT_UV        = 1;
	localparam int EV_STARTUP_UV       = 2;
	localparam int EV_OUTPUT_OV        = 3;
	localparam int EV_DEMAG_SHORT      = 4;
	localparam int EV_INPUT_UV         = 5;
	localparam int EV_INPUT_UV_BURST   = 6;
	localparam int EV_PRESTART_LOW     = 7;

	// Fixed second overcurrent levels in millivolts
	localparam logic [11:0] OCP2_LEVEL_0 = 12'h258;
	localparam logic [11:0] OCP2_LEVEL_1 = 12'h320;
	localparam logic [11:0] OCP2_LEVEL_2 = 12'h4B0;
	localparam logic [11:0] OCP2_LEVEL_3 = 12'h640;

	// Register byte offsets
	localparam logic [7:0] REG_CONTROL      = 8'h00;
	localparam logic [7:0] REG_CAP_GAIN     = 8'h04;
	localparam logic [7:0] REG_NOTCH        = 8'h08;
	localparam logic [7:0] REG_OCP_LIMIT    = 8'h0C;
	localparam logic [7:0] REG_OCP_BLANK    = 8'h10;
	localparam logic [7:0] REG_OUT_LEVELS   = 8'h14;
	localparam logic [7:0] REG_OUV_BLANK    = 8'h18;
	localparam logic [7:0] REG_OVP_LEVEL    = 8'h1C;
	localparam logic [7:0] REG_IN_LEVELS    = 8'h20;
	localparam logic [7:0] REG_START_MAX    = 8'h24;
	localparam logic [7:0] REG_STATUS       = 8'h28;
	localparam logic [7:0] REG_MASK         = 8'h2C;
	localparam logic [7:0] REG_INFO         = 8'h30;

	// Control register fields
	localparam int CTL_OUV_ENABLE    = 0;
	localparam int CTL_OUV_LATCH     = 1;
	localparam int CTL_OVP_LATCH     = 2;
	localparam int CTL_INUV_ENABLE   = 3;
	localparam int CTL_BURST_IN_EN   = 4;

	// Reset values
	localparam logic [31:0] RESET_ZERO  = 32'h0000_0000;

endpackage

// File: logic/blank_timer.sv
// Blanking counter that expires once a condition has held long enough
`timescale 1ns/10ps
module blank_timer #(
	parameter int WIDTH = 24
) (
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             rst,
	input  wire logic             clockEnable,
	// Condition and count control
	input  wire logic             condition,
	input  wire logic             step,
	input  wire logic [WIDTH-1:0] limit,
	// Result
	output logic                  expired
);

	logic [WIDTH-1:0] count_r;      // Steps counted while condition held

	// Count steps while held, restart whenever the condition drops
	always_ff @(posedge clock)
	begin
		if (rst)
			count_r <= '0;
		else if (clockEnable)
		begin
			if (!condition)
				count_r <= '0;
			else if (step && (count_r != '1))
				count_r <= count_r + 1'b1;
		end
	end

	// Expired while the condition still holds and the count reached limit
	assign expired = condition && (count_r >= limit);

endmodule

// File: bench/flyback_props.sv
// Port checker for the flyback protection monitor, with its bind
`timescale 1ns/10ps
module flyback_props #(
	parameter int SAMPLE_WIDTH = 12
) (
	// Clock and reset
	input wire logic                    clock,
	input wire logic                    rst,
	input wire logic                    clockEnable,
	// Modes and estimates
	input wire logic                    quasiResonantValleyOneMode,
	input wire logic                    discontinuousMode,
	input wire logic                    burstMode,
	input wire logic                    regulatedMode,
	input wire logic                    lineSyncValid,
	input wire logic                    feedbackStable,
	input wire logic                    demagSenseFail,
	input wire logic [SAMPLE_WIDTH-1:0] currentSense,
	input wire logic [15:0]             mappedOnTime,
	// Watched outputs
	input wire logic [15:0]             modulatedOnTime,
	input wire logic                    notchEnable,
	input wire logic                    enhancedPowerFactor,
	input wire logic                    faultClear,
	input wire logic                    gateDisable,
	input wire logic [2:0]              faultCause,
	input wire logic                    autoRestartRequest,
	input wire logic                    latchRequest
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// Fresh fault capture with a given cause
	sequence fire_s(logic [2:0] c);
		$rose(gateDisable) && faultCause == c;
	endsequence
	// Gate stays off until released
	a_gate_holds: assert property (gateDisable && !faultClear |=> gateDisable)
		else $error("gate released without clear");
	a_one_request: assert property ($rose(gateDisable) |-> autoRestartRequest != latchRequest)
		else $error("not one reaction request");
	a_request_pulse: assert property (clockEnable && (autoRestartRequest || latchRequest) |=> !autoRestartRequest && !latchRequest)
		else $error("reaction request longer than a cycle");
	a_latch_causes: assert property (latchRequest |-> faultCause == 3'h1 || faultCause == 3'h3)
		else $error("latch for fixed cause");
	a_notch_sync: assert property (notchEnable |-> lineSyncValid && (quasiResonantValleyOneMode || discontinuousMode))
		else $error("notch on without sync");
	a_mod_passthru: assert property (clockEnable && !(enhancedPowerFactor && feedbackStable && (quasiResonantValleyOneMode || discontinuousMode)) |=> modulatedOnTime == $past(mappedOnTime))
		else $error("on-time modulated while inactive");
	a_ocp_level: assert property (fire_s(3'h0) |-> $past(currentSense) > 12'h0258)
		else $error("overcurrent below lowest level");
	a_ouv_mode: assert property (fire_s(3'h1) |-> $past(regulatedMode) && !$past(burstMode))
		else $error("output undervoltage outside regulation");
	a_ovp_mode: assert property (fire_s(3'h3) |-> !$past(burstMode))
		else $error("overvoltage in burst");
	a_demag_mode: assert property (fire_s(3'h4) |-> $past(demagSenseFail) && !$past(burstMode))
		else $error("demag shortage without cause");
	a_burst_inuv: assert property (fire_s(3'h6) |-> $past(burstMode))
		else $error("burst input fault outside burst");
endmodule
bind flyback_protection_monitor flyback_props #(.SAMPLE_WIDTH(SAMPLE_WIDTH))
	u_flyback_props (.clock, .rst, .clockEnable, .quasiResonantValleyOneMode,
	.discontinuousMode, .burstMode, .regulatedMode, .lineSyncValid,
	.feedbackStable, .demagSenseFail, .currentSense, .mappedOnTime,
	.modulatedOnTime, .notchEnable, .enhancedPowerFactor, .faultClear,
	.gateDisable, .faultCause, .autoRestartRequest, .latchRequest);

// File: bench/front_end_model.sv
// Sampling front end model: estimates and burst tick
`timescale 1ns/10ps
module front_end_model #(
	parameter int BURST_CYCLES = 8
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// Commanded analog levels
	input  wire logic [11:0] inLevel,
	input  wire logic [11:0] outLevel,
	input  wire logic [11:0] csLevel,
	// Sampled estimates
	output logic      [11:0] inputVoltage,
	output logic      [11:0] outputVoltage,
	output logic      [11:0] outputCurrent,
	output logic      [11:0] currentSense,
	output logic             demagSenseFail,
	output logic             burstPeriodTick
);
	logic [7:0] tickCount_r; // Burst period counter
	// One sample per cycle, one cycle late
	always_ff @(posedge clock)
	begin
		inputVoltage   <= inLevel;
		outputVoltage  <= outLevel;
		outputCurrent  <= csLevel;
		currentSense   <= csLevel;
		demagSenseFail <= (outLevel == 12'h000);
	end
	// Burst period counter
	always_ff @(posedge clock)
	begin
		if (rst || burstPeriodTick)
			tickCount_r <= 8'h00;
		else
			tickCount_r <= tickCount_r + 8'h01;
	end
	assign burstPeriodTick = (tickCount_r == 8'(BURST_CYCLES - 1));
endmodule

// File: bench/testbench.sv
// Self-checking bench for the flyback protection monitor
`timescale 1ns/10ps
module testbench;
	localparam int HALF = 64; // Shortened preset half period
	// Row: current limit, gain, expected level select
	typedef struct packed {logic [11:0] lim; logic [7:0] gain; logic [1:0] sel;} row_t;
	row_t rows [8] = '{'{12'h0000, 8'h00, 2'h0}, '{12'h0257, 8'h01, 2'h0},
		'{12'h0258, 8'h00, 2'h1}, '{12'h031F, 8'h02, 2'h1},
		'{12'h0320, 8'h00, 2'h2}, '{12'h04AF, 8'h04, 2'h2},
		'{12'h04B0, 8'h00, 2'h3}, '{12'h0640, 8'h10, 2'h3}};
	// Design and model signals
	logic        clock, rst, clockEnable, psel, penable, pwrite, pready;
	logic        pslverr, quasiResonantValleyOneMode, discontinuousMode;
	logic        burstMode, regulatedMode, startupPhase, preStartupCheck;
	logic        lineSyncValid, burstPeriodTick, demagSenseFail;
	logic        feedbackStable, notchEnable, enhancedPowerFactor, irq;
	logic        faultClear, gateDisable, autoRestartRequest, latchRequest;
	logic [7:0]  paddr, phaseAngle;
	logic [31:0] pwdata, prdata, q;
	logic [17:0] measuredHalfPeriod;
	logic [11:0] inputVoltage, outputVoltage, outputCurrent, currentSense;
	logic [11:0] inLevel, outLevel, csLevel;
	logic [15:0] mappedOnTime, modulatedOnTime;
	logic [3:0]  notchQuality;
	logic [2:0]  faultCause;
	int          numErrors, checksDone, n;
	flyback_protection_monitor #(.PRESET_HALF_CYCLES(HALF))
	u_flyback_protection_monitor (.clock, .rst, .clockEnable, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.quasiResonantValleyOneMode, .discontinuousMode, .burstMode,
		.regulatedMode, .startupPhase, .preStartupCheck, .lineSyncValid,
		.measuredHalfPeriod, .burstPeriodTick, .inputVoltage, .outputVoltage,
		.outputCurrent, .currentSense, .demagSenseFail, .feedbackStable,
		.phaseAngle, .mappedOnTime, .modulatedOnTime, .notchEnable,
		.notchQuality, .enhancedPowerFactor, .faultClear, .gateDisable,
		.faultCause, .autoRestartRequest, .latchRequest, .irq);
	front_end_model u_front_end_model (.clock, .rst, .inLevel, .outLevel,
		.csLevel, .inputVoltage, .outputVoltage, .outputCurrent,
		.currentSense, .demagSenseFail, .burstPeriodTick);
	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp)
		begin
			numErrors++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// One APB transfer, held until pready
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1)
			@(posedge clock);
		q = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	// Count edges until the gate turns off
	task automatic waitGate();
		n = 0;
		do
		begin
			@(posedge clock);
			#1 n++;
		end
		while (gateDisable !== 1'b1 && n < 200);
	endtask
	// Release a held fault
	task automatic clearFault();
		repeat (3) @(posedge clock);
		faultClear <= 1'b1;
		@(posedge clock);
		faultClear <= 1'b0;
		#1 check(gateDisable, 32'h0000_0000);
	endtask
	// Verdict and end of run
	task automatic finalReport();
		if (numErrors == 0 && checksDone > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Free-running clock
	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// Changing on-time input
	always @(posedge clock)
		mappedOnTime <= mappedOnTime + 16'h0001;
	// Hang guard
	initial
	begin
		#1000000 numErrors++;
		finalReport();
	end
	// Main sequence
	initial
	begin
		{rst, clockEnable, burstMode, regulatedMode} = 4'hF;
		{psel, penable, pwrite, startupPhase, preStartupCheck} = 5'h00;
		{discontinuousMode, lineSyncValid, feedbackStable, faultClear} = 4'h0;
		quasiResonantValleyOneMode = 1'b1;
		{paddr, phaseAngle, pwdata, mappedOnTime} = 64'h0040_0000_0000_0000;
		measuredHalfPeriod = 18'h0_0028;
		{inLevel, outLevel, csLevel} = 36'h200_190_000;
		{numErrors, checksDone} = 64'h0;
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		for (int a = 0; a <= 48; a += 4)
		begin
			apb(1'b0, 8'(a), 32'h0);
			check(q, 32'h0000_0000);
		end
		apb(1'b0, 8'h40, 32'h0);
		check({q[30:0], pslverr}, 32'h0000_0001);
		foreach (rows[i])
		begin
			apb(1'b1, flyback_pkg::REG_OCP_LIMIT, {20'h0, rows[i].lim});
			apb(1'b1, flyback_pkg::REG_CAP_GAIN, {24'h0, rows[i].gain});
			apb(1'b0, flyback_pkg::REG_INFO, 32'h0);
			check(q[1:0], rows[i].sel);
			check(q[3], rows[i].gain != 8'h00);
			check(enhancedPowerFactor, rows[i].gain != 8'h00);
		end
		feedbackStable <= 1'b1;
		apb(1'b1, flyback_pkg::REG_OVP_LEVEL, 32'h0000_01F4);
		outLevel <= 12'h0258;
		repeat (40) @(posedge clock);
		#1 check(gateDisable, 32'h0000_0000);
		apb(1'b1, flyback_pkg::REG_OCP_LIMIT, 32'h0000_03E8);
		apb(1'b1, flyback_pkg::REG_OCP_BLANK, 32'h0000_0002);
		apb(1'b1, flyback_pkg::REG_MASK, 32'h0000_0001);
		outLevel <= 12'h0190;
		burstMode <= 1'b0;
		csLevel <= 12'h04E2;
		repeat (3) @(posedge clock);
		csLevel <= 12'h0000;
		repeat (3) @(posedge clock);
		csLevel <= 12'h04E2;
		repeat (4) @(posedge clock);
		#1 check(gateDisable, 32'h0000_0000);
		@(posedge clock);
		#1 check({gateDisable, autoRestartRequest, latchRequest, irq}, 4'hD);
		check(faultCause, 3'h0);
		@(posedge clock);
		csLevel <= 12'h0000;
		repeat (3) @(posedge clock);
		apb(1'b0, flyback_pkg::REG_STATUS, 32'h0);
		check(q, 32'h0000_0001);
		apb(1'b0, flyback_pkg::REG_STATUS, 32'h0);
		check({q[30:0], irq}, 32'h0000_0000);
		clearFault();
		apb(1'b1, flyback_pkg::REG_MASK, 32'h0000_0000);
		apb(1'b1, flyback_pkg::REG_CONTROL, 32'h0000_0004);
		for (int i = 0; i < 2; i++)
		begin
			@(posedge clock);
			lineSyncValid <= i[0];
			outLevel <= 12'h0258;
			waitGate();
			check(n, (i == 0) ? (HALF / 4 + 3) : (40 / 4 + 3));
			check({latchRequest, irq, faultCause}, 5'h13);
			@(posedge clock);
			outLevel <= 12'h0190;
			clearFault();
		end
		apb(1'b0, flyback_pkg::REG_STATUS, 32'h0);
		check(q, 32'h0000_0008);
		apb(1'b1, flyback_pkg::REG_MASK, 32'h0000_0040);
		apb(1'b1, flyback_pkg::REG_IN_LEVELS, 32'h0000_0100);
		apb(1'b1, flyback_pkg::REG_CONTROL, 32'h0000_0008);
		{burstMode, discontinuousMode, quasiResonantValleyOneMode} <= 3'h6;
		inLevel <= 12'h0080;
		repeat (120) @(posedge clock);
		#1 check(gateDisable, 32'h0000_0000);
		apb(1'b1, flyback_pkg::REG_CONTROL, 32'h0000_0018);
		waitGate();
		check(n < 100, 1'b1);
		check({autoRestartRequest, latchRequest, irq, faultCause}, 6'h2E);
		finalReport();
	end
endmodule
